// ===== verilog/pwr_seq_device.sv
// What this block does
// - Regulators on when either enable is high
// - WLAN in reset while its enable low
// - Bluetooth held in reset while its enable low
// - Power-on reset released within 110 ms
// - Host waits 150 ms before bus access
// - Host keeps both enables low 10 ms
// - Host enables Bluetooth whenever FM is used
// - Host treats all delays as minimums
`timescale 1ns/1ps
`include "pwr_seq_defs.svh"

// Synchroniser for one pin; only the last flop is read, since the first
// may still be settling
module pin_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk_sys, // Clock
    input  wire logic rst_b,   // Async reset, active low
    input  wire logic pin,     // Raw level from outside the domain
    output logic      level    // Settled level, STAGES edges late
);
    logic [STAGES-1:0] chain;

    // Shift the pin in; reset parks the chain at the idle low level
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chain <= {STAGES{1'b0}};
        end else begin
            chain <= {chain[STAGES-2:0], pin};
        end
    end

    assign level = chain[STAGES-1];
endmodule

// Holds one section in reset until its enable, the regulators and the
// internal power-on reset all agree
module section_release (
    input  wire logic clk_sys,  // Clock
    input  wire logic rst_b,    // Async reset, active low
    input  wire logic enable,   // Section enable, synchronised
    input  wire logic powered,  // Regulators on at the next edge
    input  wire logic por_done, // Internal power-on reset released
    output logic      reset_b   // Section out of reset when high
);
    wire logic next_reset_b = enable & powered & por_done;

    // Registered so a section never sees a glitch on its reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reset_b <= 1'b0;
        end else begin
            reset_b <= next_reset_b;
        end
    end
endmodule

// Internal power-on reset timer
module por_timer #(
    parameter longint CYCLES = `POR_MAX_CYC
) (
    input  wire logic clk_sys,   // Clock
    input  wire logic rst_b,     // Async reset, active low
    input  wire logic supply_on, // Supplies above threshold, synchronised
    output logic      done       // Internal power-on reset released
);
    logic [31:0] count;
    // Trimmed target: sync and output edges eat the margin, so release
    // still lands inside the ceiling
    wire logic hit = (count >= 32'(CYCLES - `POR_MARGIN_CYC));

    // Counts only while supplies stay up; a dip starts it over
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h0;
            done  <= 1'b0;
        end else if (!supply_on) begin
            count <= 32'h0;
            done  <= 1'b0;
        end else if (hit) begin
            done <= 1'b1;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

module pwr_seq_device #(
    parameter longint POR_CYCLES = `POR_MAX_CYC
) (
    input  wire logic clk_sys,          // 200 MHz clock
    input  wire logic rst_b,            // Async reset, active low
    input  wire logic supplies_ok,      // Core and I/O supplies above threshold
    pwr_seq_if.dev    link,             // Enables from host
    output logic      regulator_on,     // Internal regulators enabled
    output logic      por_done,         // Internal power-on reset released
    output logic      wlan_reset_b,     // WLAN section out of reset when high
    output logic      bt_reset_b        // Bluetooth/FM section out of reset when high
);
    // Settled pin levels, two edges behind the pins
    logic wl_on;
    logic bt_on;
    logic sup_on;
    // What the regulator register takes at the next edge
    logic next_regulator_on;

    // Enables come from the host's pins, supplies from the analog side
    pin_sync #(
        .STAGES (2)
    ) wl_sync_i (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (link.wlan_power_enable),
        .level   (wl_on)
    );

    pin_sync #(
        .STAGES (2)
    ) bt_sync_i (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (link.bluetooth_power_enable),
        .level   (bt_on)
    );

    pin_sync #(
        .STAGES (2)
    ) sup_sync_i (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (supplies_ok),
        .level   (sup_on)
    );

    // Either enable keeps the shared regulators up
    assign next_regulator_on = wl_on | bt_on;

    // Regulator control, registered like the section resets
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            regulator_on <= 1'b0;
        end else begin
            regulator_on <= next_regulator_on;
        end
    end

    // Internal power-on reset; restarts on any supply dip
    por_timer #(
        .CYCLES (POR_CYCLES)
    ) por_timer_i (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .supply_on (sup_on),
        .done      (por_done)
    );

    // WLAN runs on its own enable once the power-on reset is released
    section_release wlan_release_i (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .enable   (wl_on),
        .powered  (next_regulator_on),
        .por_done (por_done),
        .reset_b  (wlan_reset_b)
    );

    // Bluetooth and FM share one reset, held while their enable is low even
    // when WLAN keeps the regulators up
    section_release bt_release_i (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .enable   (bt_on),
        .powered  (next_regulator_on),
        .por_done (por_done),
        .reset_b  (bt_reset_b)
    );
endmodule

// ===== verilog/pwr_seq_defs.svh
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH

// Clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS     64'd5000
// Longest power-on reset hold, in ms
`define POR_MAX_MS        64'd110
// Least wait before bus access, in ms
`define BUS_WAIT_MIN_MS   64'd150
// Least off time between power cycles, in ms
`define OFF_MIN_MS        64'd10
// Sleep clock cycles to wait after the I/O supply is valid
`define SLEEP_WAIT_CYC    8'd2
// Edges trimmed off the power-on count: two sync, one output, one spare
`define POR_MARGIN_CYC    64'd4
// Cycle counts: longest rounds down, least rounds up
`define POR_MAX_CYC       ((`POR_MAX_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define BUS_WAIT_MIN_CYC  ((`BUS_WAIT_MIN_MS * 64'd1000000000 + `CLK_PERIOD_PS - 64'd1) / `CLK_PERIOD_PS)
`define OFF_MIN_CYC       ((`OFF_MIN_MS * 64'd1000000000 + `CLK_PERIOD_PS - 64'd1) / `CLK_PERIOD_PS)

`endif

// ===== verilog/pwr_seq_pkg.sv
package pwr_seq_pkg;
    // Host sequencing states
    typedef enum logic [2:0] {
        H_SUPPLY,
        H_SLEEP_WAIT,
        H_OFF_WAIT,
        H_READY,
        H_ON
    } host_state_t;
endpackage

// ===== verilog/pwr_seq_if.sv
`timescale 1ns/1ps
interface pwr_seq_if;
    logic wlan_power_enable;      // Host to device, WLAN enable
    logic bluetooth_power_enable; // Host to device, Bluetooth enable
    modport dev  (input wlan_power_enable, input bluetooth_power_enable);
    modport host (output wlan_power_enable, output bluetooth_power_enable);
endinterface

// ===== verilog/pwr_seq_host.sv
`timescale 1ns/1ps
`include "pwr_seq_defs.svh"
module pwr_seq_host #(
    parameter longint BUS_WAIT_CYCLES = `BUS_WAIT_MIN_CYC,
    parameter longint OFF_CYCLES      = `OFF_MIN_CYC
) (
    input  wire logic clk_sys,      // 200 MHz clock
    input  wire logic rst_b,        // Async reset, active low
    input  wire logic io_supply_ok, // I/O supply valid
    input  wire logic sleep_clk,    // Slow sleep clock, sampled
    input  wire logic want_wlan,    // User wants WLAN on
    input  wire logic want_bt,      // User wants Bluetooth on
    input  wire logic want_fm,      // User wants FM on
    pwr_seq_if.host   link,         // Enables to device
    output logic      bus_ready     // Bus access allowed
);
    logic [1:0] sup_sync;
    logic [2:0] slk_sync;
    logic [7:0] slk_cnt;
    logic [31:0] cnt;
    // Own off-time counter, so a power cycle never fakes the bus wait
    logic [31:0] off_cnt;
    logic wl_q;
    logic bt_q;
    pwr_seq_pkg::host_state_t state;

    // Supply and sleep clock cross in through two flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sup_sync <= 2'h0;
            slk_sync <= 3'h0;
        end else begin
            sup_sync <= {sup_sync[0], io_supply_ok};
            slk_sync <= {slk_sync[1:0], sleep_clk};
        end
    end

    wire logic sup_on = sup_sync[1];
    wire logic slk_rise = slk_sync[1] & ~slk_sync[2];
    wire logic want_any = want_wlan | want_bt | want_fm;
    wire logic next_bt = want_bt | want_fm;
    wire logic bus_hit = (cnt >= 32'(BUS_WAIT_CYCLES));
    wire logic off_hit = (off_cnt >= 32'(OFF_CYCLES));

    assign link.wlan_power_enable      = wl_q;
    assign link.bluetooth_power_enable = bt_q;

    // Sequencer: every wait is a floor, longer is fine
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state     <= pwr_seq_pkg::H_SUPPLY;
            cnt       <= 32'h0;
            off_cnt   <= 32'h0;
            slk_cnt   <= 8'h0;
            wl_q      <= 1'b0;
            bt_q      <= 1'b0;
            bus_ready <= 1'b0;
        end else if (!sup_on) begin
            state     <= pwr_seq_pkg::H_SUPPLY;
            cnt       <= 32'h0;
            off_cnt   <= 32'h0;
            slk_cnt   <= 8'h0;
            wl_q      <= 1'b0;
            bt_q      <= 1'b0;
            bus_ready <= 1'b0;
        end else begin
            if (!bus_hit) begin
                cnt <= cnt + 32'h1;
            end
            bus_ready <= bus_hit && wl_q;
            case (state)
                pwr_seq_pkg::H_SUPPLY: begin
                    state <= pwr_seq_pkg::H_SLEEP_WAIT;
                end
                pwr_seq_pkg::H_SLEEP_WAIT: begin
                    if (slk_rise) begin
                        slk_cnt <= slk_cnt + 8'h1;
                    end
                    if (slk_cnt >= `SLEEP_WAIT_CYC) begin
                        state <= pwr_seq_pkg::H_READY;
                    end
                end
                pwr_seq_pkg::H_READY: begin
                    if (want_any) begin
                        wl_q  <= want_wlan;
                        bt_q  <= next_bt;
                        state <= pwr_seq_pkg::H_ON;
                    end
                end
                pwr_seq_pkg::H_ON: begin
                    wl_q <= want_wlan;
                    bt_q <= next_bt;
                    if (!want_any) begin
                        wl_q  <= 1'b0;
                        bt_q  <= 1'b0;
                        off_cnt <= 32'h0;
                        state <= pwr_seq_pkg::H_OFF_WAIT;
                    end
                end
                pwr_seq_pkg::H_OFF_WAIT: begin
                    off_cnt <= off_cnt + 32'h1;
                    if (off_hit) begin
                        state <= pwr_seq_pkg::H_READY;
                    end
                end
                default: begin
                    state <= pwr_seq_pkg::H_SUPPLY;
                end
            endcase
        end
    end
endmodule

// ===== tb/pwr_seq_chk.sv
`timescale 1ns/1ps
// Watches the link and the user sides of both ends
module pwr_seq_chk #(
    parameter longint POR_CYCLES      = 50,
    parameter longint BUS_WAIT_CYCLES = 100,
    parameter longint OFF_CYCLES      = 20
) (
    input wire logic clk_sys,                // Clock
    input wire logic rst_b,                  // Reset
    input wire logic wlan_power_enable,      // Link
    input wire logic bluetooth_power_enable, // Link
    input wire logic supplies_ok,            // Supplies
    input wire logic io_supply_ok,           // I/O supply
    input wire logic sleep_clk,              // Sleep clock
    input wire logic want_bt,                // Request
    input wire logic want_fm,                // Request
    input wire logic regulator_on,           // Regulators
    input wire logic por_done,               // POR done
    input wire logic wlan_reset_b,           // WLAN run
    input wire logic bt_reset_b,             // BT run
    input wire logic bus_ready               // Bus allowed
);
    longint     sup_cnt, io_cnt, off_cnt;
    logic [1:0] sl_cnt;
    logic       sl_q;
    wire        en_any = wlan_power_enable | bluetooth_power_enable;
    // Reset counts as a long enough off time, so the first enable is legal
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sup_cnt <= 0;
            io_cnt  <= 0;
            off_cnt <= OFF_CYCLES;
            sl_cnt  <= 2'h0;
            sl_q    <= 1'b0;
        end else begin
            sup_cnt <= supplies_ok ? sup_cnt + 1 : 0;
            io_cnt  <= io_supply_ok ? io_cnt + 1 : 0;
            off_cnt <= en_any ? 0 : off_cnt + 1;
            sl_q    <= sleep_clk;
            if (!io_supply_ok) sl_cnt <= 2'h0;
            else if (sleep_clk && !sl_q && sl_cnt != 2'h3) sl_cnt <= sl_cnt + 2'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_reg_follow: assert property (regulator_on == $past(en_any, 3))
        else $error("regulator lag wrong");
    a_wlan_held: assert property (!$past(wlan_power_enable, 3) |-> !wlan_reset_b)
        else $error("wlan out of reset");
    a_wlan_run: assert property ($past(wlan_power_enable, 3) && por_done
        && $past(por_done) |-> wlan_reset_b)
        else $error("wlan stuck in reset");
    a_bt_run: assert property ($past(bluetooth_power_enable, 3) && por_done
        && $past(por_done) |-> bt_reset_b)
        else $error("bt stuck in reset");
    a_bt_held: assert property (!$past(bluetooth_power_enable, 3) |-> !bt_reset_b)
        else $error("bt out of reset");
    a_por_bound: assert property (sup_cnt > POR_CYCLES |-> por_done)
        else $error("por too long");
    a_bus_wait: assert property (bus_ready |-> io_cnt >= BUS_WAIT_CYCLES)
        else $error("bus ready early");
    a_bus_wlan: assert property (bus_ready |-> $past(wlan_power_enable))
        else $error("bus ready without wlan");
    a_off_gap: assert property ($rose(en_any) |-> off_cnt >= OFF_CYCLES - 1)
        else $error("off gap short");
    a_fm_needs_bt: assert property ($rose(bluetooth_power_enable) |-> $past(want_bt | want_fm))
        else $error("bt raised unasked");
    a_sleep_first: assert property ($rose(en_any) |-> sl_cnt >= 2'h2)
        else $error("enable before sleep wait");
endmodule

// ===== tb/regulator_enable_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
module regulator_enable_reset_sequencer_tb_top;
    logic clk_sys, rst_b, supplies_ok, io_supply_ok, sleep_clk, want_wlan, want_bt, want_fm;
    logic regulator_on, por_done, wlan_reset_b, bt_reset_b, bus_ready;
    int   n_fail, samples_checked;
    pwr_seq_if pwr_seq_if_i ();
    pwr_seq_device #(.POR_CYCLES(50)) pwr_seq_device_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .supplies_ok(supplies_ok), .link(pwr_seq_if_i.dev), .regulator_on(regulator_on),
        .por_done(por_done), .wlan_reset_b(wlan_reset_b), .bt_reset_b(bt_reset_b));
    pwr_seq_host #(.BUS_WAIT_CYCLES(100), .OFF_CYCLES(20)) pwr_seq_host_i (.clk_sys(clk_sys),
        .rst_b(rst_b), .io_supply_ok(io_supply_ok), .sleep_clk(sleep_clk),
        .want_wlan(want_wlan), .want_bt(want_bt), .want_fm(want_fm),
        .link(pwr_seq_if_i.host), .bus_ready(bus_ready));
    pwr_seq_chk #(.POR_CYCLES(50), .BUS_WAIT_CYCLES(100), .OFF_CYCLES(20))
        pwr_seq_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .wlan_power_enable(pwr_seq_if_i.wlan_power_enable),
        .bluetooth_power_enable(pwr_seq_if_i.bluetooth_power_enable),
        .supplies_ok(supplies_ok), .io_supply_ok(io_supply_ok), .sleep_clk(sleep_clk),
        .want_bt(want_bt), .want_fm(want_fm), .regulator_on(regulator_on),
        .por_done(por_done), .wlan_reset_b(wlan_reset_b), .bt_reset_b(bt_reset_b),
        .bus_ready(bus_ready));
    // Inputs change 1 ns after the edge, never on it
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Requests in order wlan, bt, fm
    task automatic ask(input logic [2:0] w);
        {want_wlan, want_bt, want_fm} = w;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Sleep clock 20 cycles a period: slow enough that the wait is seen
    initial begin
        sleep_clk = 1'b0;
        forever begin
            step(10);
            sleep_clk = ~sleep_clk;
        end
    end
    initial begin
        #5000;
        n_fail++;
        results();
    end
    initial begin
        n_fail = 0;
        samples_checked = 0;
        {rst_b, supplies_ok, io_supply_ok} = 3'h0;
        ask(3'h0);
        step(4);
        {rst_b, supplies_ok, io_supply_ok} = 3'h7;
        step(60);
        chk("por_done", 1'b1, por_done);
        ask(3'h4);
        step(10);
        chk("regulator_on", 1'b1, regulator_on);
        chk("wlan_reset_b", 1'b1, wlan_reset_b);
        chk("bt_reset_b", 1'b0, bt_reset_b);
        step(100);
        chk("bus_ready", 1'b1, bus_ready);
        ask(3'h5);
        step(10);
        chk("bt_reset_b", 1'b1, bt_reset_b);
        ask(3'h2);
        step(10);
        chk("wlan_reset_b", 1'b0, wlan_reset_b);
        chk("regulator_on", 1'b1, regulator_on);
        chk("bus_ready", 1'b0, bus_ready);
        ask(3'h0);
        step(10);
        chk("regulator_on", 1'b0, regulator_on);
        ask(3'h2);
        step(10);
        chk("regulator_on", 1'b0, regulator_on);
        step(30);
        chk("bt_reset_b", 1'b1, bt_reset_b);
        {supplies_ok, io_supply_ok} = 2'h0;
        step(10);
        chk("por_done", 1'b0, por_done);
        chk("regulator_on", 1'b0, regulator_on);
        results();
    end
endmodule
